//--- hdl/port_a_io_port.sv
// What this block does
// [RL1] A pin drives out when its direction bit is 1, else it is input.
// [RL2] In mode 3 pin 7 direction stays 1 and pin 7 outputs address.
// [RL3] Direction register is write-only and always reads back all ones.
// [RL4] Reset or hardware standby loads direction 0x00, or 0x80 in mode 3.
// [RL5] Software standby keeps direction; output pins keep driving.
// [RL6] Data latch clears on reset and hardware standby, holds in software standby.
// [RL7] Port read gives latch bit for outputs and pin level for inputs.
// [RL8] Enabled next-data bits ignore CPU writes and take buffer transfers only.
// [RL9] Latch supplies the pattern output values of groups 0 and 1.
// [RL10] Software sets direction bits for pins used as pattern outputs.
`timescale 1ns/1ps
`default_nettype none

module port_a_io_port (
    // Clock and reset.
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave.
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [port_a_pkg::ADDR_W-1:0] paddr,
    input  wire logic [port_a_pkg::DATA_W-1:0] pwdata,
    output logic      [port_a_pkg::DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Operating mode strap and standby controls.
    input  wire logic [2:0]                    mode,
    input  wire logic                          hw_standby,
    input  wire logic                          sw_standby,
    // Timing pattern unit transfer.
    input  wire logic [7:0]                    next_data_enable_a,
    input  wire logic [7:0]                    next_data_buffer_a,
    input  wire logic                          next_data_load,
    // Address bit for pin 7 in address mode.
    input  wire logic                          address_a20,
    // Port pins.
    input  wire logic [7:0]                    pin_in,
    output logic      [7:0]                    pin_out,
    output logic      [7:0]                    pin_oe
);

    typedef enum logic {
        BOOT_LOAD,
        BOOT_RUN
    } boot_e;

    typedef struct packed {
        boot_e                         boot;
        logic                          addr_mode;
        logic [7:0]                    dir;
        logic [7:0]                    latch;
        logic                          ready;
        logic                          err;
        logic [port_a_pkg::DATA_W-1:0] rdata;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic       setup;
    logic       commit;
    logic       hit_dir;
    logic       hit_latch;
    logic       wr_dir;
    logic       wr_latch;
    logic [7:0] dir_eff;

    // Direction reset value for a given mode.
    function automatic logic [7:0] dir_init(input logic addr_mode_f);
        dir_init = addr_mode_f ? port_a_pkg::DIR_RST_MODE3
                               : port_a_pkg::DIR_RST_NORMAL;
    endfunction

    // Per-bit port read: latch for outputs, pin level for inputs.
    function automatic logic [7:0] port_read(input logic [7:0] dir_f,
                                             input logic [7:0] latch_f,
                                             input logic [7:0] pins_f);
        port_read = (latch_f & dir_f) | (pins_f & ~dir_f);
    endfunction

    // Address decode and commit strobes.
    port_a_bus_decode u_decode (
        .pclk      (pclk),
        .presetn   (presetn),
        .paddr     (paddr),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .pready_q  (st_q.ready),
        .setup     (setup),
        .commit    (commit),
        .hit_dir   (hit_dir),
        .hit_latch (hit_latch),
        .wr_dir    (wr_dir),
        .wr_latch  (wr_latch)
    );

    // Pin 7 effective direction is always 1 in address mode; hardware standby still releases the pin.
    always_comb begin
        dir_eff = st_q.dir;
        if (st_q.addr_mode) begin
            dir_eff = st_q.dir | port_a_pkg::PIN7_MASK; // RL2
        end
    end

    // Next-state logic for the whole port.
    always_comb begin
        st_d = st_q;

        // Bus answer: pready rises the cycle after setup, for one cycle.
        st_d.ready = setup && !st_q.ready;
        st_d.err   = setup && !st_q.ready && !(hit_dir || hit_latch);
        if (setup && !st_q.ready) begin
            if (hit_dir) begin
                st_d.rdata = {24'h000000, port_a_pkg::DIR_READ_VALUE}; // RL3
            end else if (hit_latch) begin
                st_d.rdata = {24'h000000,
                              port_read(dir_eff, st_q.latch, pin_in)}; // RL7
            end else begin
                st_d.rdata = port_a_pkg::UNMAPPED_READ;
            end
        end

        unique case (st_q.boot)
            BOOT_LOAD: begin
                // Catch the mode strap once after reset release.
                st_d.addr_mode = (mode == port_a_pkg::MODE_ADDR_PIN7);
                st_d.dir       = dir_init(mode == port_a_pkg::MODE_ADDR_PIN7); // RL4
                st_d.latch     = port_a_pkg::LATCH_RST; // RL6
                st_d.boot      = BOOT_RUN;
            end
            BOOT_RUN: begin
                if (hw_standby) begin
                    st_d.dir   = dir_init(st_q.addr_mode); // RL4
                    st_d.latch = port_a_pkg::LATCH_RST; // RL6
                end else begin
                    // Software standby changes nothing by itself.
                    if (wr_dir) begin
                        st_d.dir = pwdata[7:0]; // RL1
                    end
                    if (wr_latch) begin
                        st_d.latch = (pwdata[7:0] & ~next_data_enable_a)
                                   | (st_q.latch & next_data_enable_a); // RL8
                    end
                    if (next_data_load) begin
                        st_d.latch = (st_d.latch & ~next_data_enable_a)
                                   | (next_data_buffer_a & next_data_enable_a); // RL8
                    end
                end
                if (st_d.addr_mode) begin
                    st_d.dir[port_a_pkg::PIN7_POS] = 1'b1; // RL2
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.boot      <= BOOT_LOAD;
            st_q.addr_mode <= 1'b0;
            st_q.dir       <= port_a_pkg::DIR_RST_NORMAL;
            st_q.latch     <= port_a_pkg::LATCH_RST;
            st_q.ready     <= 1'b0;
            st_q.err       <= 1'b0;
            st_q.rdata     <= port_a_pkg::UNMAPPED_READ;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata  = st_q.rdata;
    assign pready  = st_q.ready;
    assign pslverr = st_q.err;

    // Registered pin drive; the latch feeds pattern outputs directly.
    port_a_pin_stage u_pins (
        .pclk        (pclk),
        .presetn     (presetn),
        .dir_eff     (dir_eff),
        .latch       (st_q.latch), // RL9
        .addr_mode   (st_q.addr_mode),
        .address_a20 (address_a20),
        .hw_standby  (hw_standby),
        .pin_out     (pin_out),
        .pin_oe      (pin_oe)
    ); // RL5

    // Named steps of a register access.
    sequence s_read_dir;
        setup && !pwrite && hit_dir && !pready;
    endsequence

    sequence s_read_latch;
        setup && !pwrite && hit_latch && !pready;
    endsequence

    sequence s_run;
        st_q.boot == BOOT_RUN && !hw_standby;
    endsequence

    // Output enables follow the effective direction one cycle later.
    property p_oe_follows_dir;
        @(posedge pclk) disable iff (!presetn)
            s_run |=> (pin_oe == $past(dir_eff));
    endproperty
    a_oe_follows_dir: assert property (p_oe_follows_dir) // RL1
        else $error("Output enable does not follow direction.");

    // Pin 7 stays output and carries the address in address mode.
    property p_pin7_addr;
        @(posedge pclk) disable iff (!presetn)
            (st_q.addr_mode && st_q.boot == BOOT_RUN && !hw_standby) |=>
                (pin_oe[7] && pin_out[7] == $past(address_a20));
    endproperty
    a_pin7_addr: assert property (p_pin7_addr) // RL2
        else $error("Pin 7 is not an address output in address mode.");

    // A direction read answers all ones on the next cycle.
    property p_dir_reads_ones;
        @(posedge pclk) disable iff (!presetn)
            s_read_dir |=> (pready && prdata[7:0] == 8'hff && !pslverr);
    endproperty
    a_dir_reads_ones: assert property (p_dir_reads_ones) // RL3
        else $error("Direction read did not return all ones.");

    // Hardware standby loads the mode-dependent direction value.
    property p_hw_dir_init;
        @(posedge pclk) disable iff (!presetn)
            (hw_standby && st_q.boot == BOOT_RUN) |=>
                (st_q.dir == (st_q.addr_mode ? 8'h80 : 8'h00));
    endproperty
    a_hw_dir_init: assert property (p_hw_dir_init) // RL4
        else $error("Direction not initialised in hardware standby.");

    // Software standby without writes keeps the direction register.
    property p_sw_dir_hold;
        @(posedge pclk) disable iff (!presetn)
            (s_run and (sw_standby && !wr_dir)) |=> $stable(st_q.dir);
    endproperty
    a_sw_dir_hold: assert property (p_sw_dir_hold) // RL5
        else $error("Direction changed in software standby.");

    // Hardware standby clears the latch; quiet software standby holds it.
    property p_latch_standby;
        @(posedge pclk) disable iff (!presetn)
            (hw_standby |=> st_q.latch == 8'h00) and
            ((s_run and (sw_standby && !wr_latch && !next_data_load))
                |=> $stable(st_q.latch));
    endproperty
    a_latch_standby: assert property (p_latch_standby) // RL6
        else $error("Data latch standby behaviour wrong.");

    // A latch read mixes latch and pin level by direction.
    property p_latch_read;
        logic [7:0] v;
        @(posedge pclk) disable iff (!presetn)
            (s_read_latch, v = port_read(dir_eff, st_q.latch, pin_in))
                |=> (pready && prdata[7:0] == v);
    endproperty
    a_latch_read: assert property (p_latch_read) // RL7
        else $error("Port read value wrong.");

    // Enabled bits ignore CPU writes when no transfer happens.
    property p_enabled_ignore_write;
        @(posedge pclk) disable iff (!presetn)
            (s_run and (wr_latch && !next_data_load)) |=>
                ((st_q.latch & $past(next_data_enable_a))
                 == ($past(st_q.latch) & $past(next_data_enable_a)));
    endproperty
    a_enabled_ignore_write: assert property (p_enabled_ignore_write) // RL8
        else $error("CPU write reached an enabled latch bit.");

    // Transfers load enabled bits from the buffer.
    property p_transfer_loads;
        @(posedge pclk) disable iff (!presetn)
            (s_run and next_data_load) |=>
                ((st_q.latch & $past(next_data_enable_a))
                 == ($past(next_data_buffer_a) & $past(next_data_enable_a)));
    endproperty
    a_transfer_loads: assert property (p_transfer_loads) // RL8
        else $error("Transfer did not load enabled latch bits.");

    // Driven pattern pins show the latch one cycle later.
    property p_pattern_out;
        @(posedge pclk) disable iff (!presetn)
            (s_run and !st_q.addr_mode) |=> (pin_out == $past(st_q.latch));
    endproperty
    a_pattern_out: assert property (p_pattern_out) // RL9
        else $error("Pin output does not show the data latch.");

    // Boot captures the mode, loads its direction value and clears the latch.
    property p_boot_load;
        @(posedge pclk) disable iff (!presetn)
            (st_q.boot == BOOT_LOAD) |=>
                (st_q.addr_mode == ($past(mode) == 3'h3) && st_q.latch == 8'h00
                 && st_q.dir == (st_q.addr_mode ? 8'h80 : 8'h00));
    endproperty
    a_boot_load: assert property (p_boot_load) // RL4
        else $error("Boot did not load direction and latch.");

    // A direction write lands, with pin 7 forced in address mode.
    property p_dir_write;
        @(posedge pclk) disable iff (!presetn)
            (s_run and wr_dir) |=>
                (st_q.dir == ($past(pwdata[7:0]) | (st_q.addr_mode ? 8'h80 : 8'h00)));
    endproperty
    a_dir_write: assert property (p_dir_write) // RL1
        else $error("Direction write did not land.");

    // A CPU write lands on the latch bits that the pattern unit does not own.
    property p_free_bits_written;
        @(posedge pclk) disable iff (!presetn)
            (s_run and (wr_latch && !next_data_load)) |=>
                ((st_q.latch & ~$past(next_data_enable_a))
                 == ($past(pwdata[7:0]) & ~$past(next_data_enable_a)));
    endproperty
    a_free_bits_written: assert property (p_free_bits_written) // RL8
        else $error("CPU write missed a free latch bit.");

    // An unmapped access answers with an error and zero data.
    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
            (setup && !hit_dir && !hit_latch && !pready) |=>
                (pready && pslverr && prdata == port_a_pkg::UNMAPPED_READ);
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("Unmapped access did not answer with an error.");

    // The bus answer stands for exactly one cycle.
    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
            pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("Bus answer stood longer than one cycle.");

    // Read data carries only the port byte; the upper bits stay zero.
    property p_rdata_upper_zero;
        @(posedge pclk) disable iff (!presetn)
            pready |-> (prdata[31:8] == 24'h000000);
    endproperty
    a_rdata_upper_zero: assert property (p_rdata_upper_zero) // RL7
        else $error("Read data upper bits are not zero.");

endmodule // port_a_io_port

`default_nettype wire

//--- pkg/port_a_pkg.sv
`default_nettype none

// Constants shared by the port A register file, decoder and pin stage.
package port_a_pkg;

    // APB address width and data width.
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [15:0] DIR_INDEX   = 16'hffd1;
    localparam logic [15:0] LATCH_INDEX = 16'hffd3;
    localparam logic [ADDR_W-1:0] DIR_ADDR   = {2'h0, DIR_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] LATCH_ADDR = {2'h0, LATCH_INDEX, 2'h0};

    // Reset and read values.
    localparam logic [7:0] DIR_RST_NORMAL = 8'h00;
    localparam logic [7:0] DIR_RST_MODE3  = 8'h80;
    localparam logic [7:0] LATCH_RST      = 8'h00;
    localparam logic [7:0] DIR_READ_VALUE = 8'hff;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // Operating mode code that turns pin 7 into an address output.
    localparam logic [2:0] MODE_ADDR_PIN7 = 3'h3;

    // Position of pin 7 inside the port byte.
    localparam int PIN7_POS = 7;

    // Forced direction mask for pin 7 in the address mode.
    localparam logic [7:0] PIN7_MASK = 8'h80;

endpackage : port_a_pkg

`default_nettype wire

//--- hdl/port_a_bus_decode.sv
`timescale 1ns/1ps
`default_nettype none

module port_a_bus_decode (
    // Clock and reset for the checks below.
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB request.
    input  wire logic [port_a_pkg::ADDR_W-1:0] paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic                          pready_q,
    // Decoded strobes.
    output logic                               setup,
    output logic                               commit,
    output logic                               hit_dir,
    output logic                               hit_latch,
    output logic                               wr_dir,
    output logic                               wr_latch
);

    // Address match against the two word addresses.
    always_comb begin
        hit_dir   = (paddr == port_a_pkg::DIR_ADDR);
        hit_latch = (paddr == port_a_pkg::LATCH_ADDR);
    end

    // A request is taken in setup and committed when pready is seen high.
    always_comb begin
        setup    = psel && !penable;
        commit   = psel && penable && pready_q;
        wr_dir   = commit && pwrite && hit_dir;
        wr_latch = commit && pwrite && hit_latch;
    end

    // A commit only ever follows a setup cycle, so no write lands unannounced.
    property p_commit_after_setup;
        @(posedge pclk) disable iff (!presetn) commit |-> $past(setup);
    endproperty
    a_commit_after_setup: assert property (p_commit_after_setup)
        else $error("Commit without a preceding setup cycle.");

endmodule // port_a_bus_decode

`default_nettype wire

//--- hdl/port_a_pin_stage.sv
`timescale 1ns/1ps
`default_nettype none

module port_a_pin_stage (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Sources for the pins.
    input  wire logic [7:0] dir_eff,
    input  wire logic [7:0] latch,
    input  wire logic       addr_mode,
    input  wire logic       address_a20,
    input  wire logic       hw_standby,
    // Registered pin drive.
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe
);

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_s;

    pin_s st_q;
    pin_s st_d;

    // Latch bits drive the pins; pin 7 carries the address in address mode.
    always_comb begin
        st_d.out = latch;
        st_d.oe  = hw_standby ? 8'h00 : dir_eff;
        if (addr_mode) begin
            st_d.out[port_a_pkg::PIN7_POS] = address_a20;
        end
    end

    // Pin drive registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_out = st_q.out;
    assign pin_oe  = st_q.oe;

    // Hardware standby releases every pin on the next edge.
    property p_hw_release;
        @(posedge pclk) disable iff (!presetn) hw_standby |=> (pin_oe == 8'h00);
    endproperty
    a_hw_release: assert property (p_hw_release)
        else $error("Pins still driven in hardware standby.");

endmodule // port_a_pin_stage

`default_nettype wire

//--- dv/port_a_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module port_a_far_side (
    // Clock and pins.
    input  wire logic       pclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_level,
    output logic      [7:0] pin_in,
    // Transfer towards the port latch.
    output logic      [7:0] next_data_enable_a,
    output logic      [7:0] next_data_buffer_a,
    output logic            next_data_load
);
    // A driven pin reads back its own drive, an input pin the outside level.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);

    // Quiet transfer interface from time zero.
    initial begin
        next_data_enable_a = 8'h00;
        next_data_buffer_a = 8'h00;
        next_data_load     = 1'b0;
    end

    // Sets which latch bits belong to the pattern unit.
    task automatic set_enable(input logic [7:0] en);
        @(posedge pclk);
        next_data_enable_a <= en;
    endtask

    // One-cycle load; the buffer is inverted afterwards so stale data never matches.
    task automatic transfer(input logic [7:0] data);
        @(posedge pclk);
        next_data_buffer_a <= data;
        next_data_load     <= 1'b1;
        @(posedge pclk);
        next_data_load     <= 1'b0;
        next_data_buffer_a <= ~data;
    endtask
endmodule // port_a_far_side

`default_nettype wire

//--- dv/port_a_io_port_test.sv
`timescale 1ns/1ps
`default_nettype none

module port_a_io_port_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [19:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  mode;
    logic        hw_standby;
    logic        sw_standby;
    logic [7:0]  nde;
    logic [7:0]  ndb;
    logic        ndl;
    logic        address_a20;
    logic [7:0]  pin_in;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  ext_level;
    int          err_total;
    int          checked;

    port_a_io_port dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode(mode), .hw_standby(hw_standby), .sw_standby(sw_standby),
        .next_data_enable_a(nde), .next_data_buffer_a(ndb), .next_data_load(ndl),
        .address_a20(address_a20), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
    );

    port_a_far_side far_u (
        .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in), .next_data_enable_a(nde), .next_data_buffer_a(ndb),
        .next_data_load(ndl)
    );

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compares a seen value against its expectation.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [19:0] addr, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            $display("MISMATCH pready expected 1 seen %b", pready);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write that expects no error response.
    task automatic wr(input logic [19:0] addr, input logic [7:0] data);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, addr, data, rd, err);
        check("write pslverr", 32'h0, {31'h0, err});
    endtask

    // Register read compared with data and error expectations.
    task automatic rd_chk(input string what, input logic [19:0] addr,
                          input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, addr, 8'h00, rd, err);
        check(what, exp, rd);
        check("read pslverr", {31'h0, experr}, {31'h0, err});
    endtask

    // Resets the port with a given mode strap, ending on the first edge after release.
    task automatic do_reset(input logic [2:0] m);
        @(posedge pclk);
        presetn <= 1'b0;
        mode    <= m;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        finish_test();
    end

    // Main sequence.
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 20'h0; pwdata = 32'h0; mode = 3'h1; hw_standby = 1'b0;
        sw_standby = 1'b0; address_a20 = 1'b0; ext_level = 8'ha5;
        err_total = 0; checked = 0;
        do_reset(3'h1);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check("oe after reset", 32'h0, {24'h0, pin_oe});
        check("out after reset", 32'h0, {24'h0, pin_out});
        rd_chk("read all inputs", port_a_pkg::LATCH_ADDR, 32'ha5, 1'b0);
        rd_chk("direction read", port_a_pkg::DIR_ADDR, 32'hff, 1'b0);
        wr(port_a_pkg::DIR_ADDR, 8'h0f);
        wr(port_a_pkg::LATCH_ADDR, 8'h3c);
        rd_chk("direction reread", port_a_pkg::DIR_ADDR, 32'hff, 1'b0);
        rd_chk("mixed read", port_a_pkg::LATCH_ADDR, 32'hac, 1'b0);
        @(negedge pclk);
        check("oe follows direction", 32'h0f, {24'h0, pin_oe});
        check("low pins drive", 32'h0c, {28'h0, pin_out[3:0]});
        rd_chk("unmapped read", 20'h00100, 32'h0, 1'b1);
        // Pattern output: direction set first, then two bits handed to the unit.
        wr(port_a_pkg::DIR_ADDR, 8'hff);
        far_u.set_enable(8'h03);
        wr(port_a_pkg::LATCH_ADDR, 8'hff);
        rd_chk("enabled bits kept", port_a_pkg::LATCH_ADDR, 32'hfc, 1'b0);
        far_u.transfer(8'h01);
        @(posedge pclk);
        @(negedge pclk);
        check("pattern drive", 32'hfd, {24'h0, pin_out});
        rd_chk("after transfer", port_a_pkg::LATCH_ADDR, 32'hfd, 1'b0);
        // Software standby keeps everything driving.
        @(posedge pclk);
        sw_standby <= 1'b1;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        check("oe in sw standby", 32'hff, {24'h0, pin_oe});
        check("out in sw standby", 32'hfd, {24'h0, pin_out});
        @(posedge pclk);
        sw_standby <= 1'b0;
        // Hardware standby releases pins and reinitialises both registers.
        far_u.set_enable(8'h00);
        @(posedge pclk);
        hw_standby <= 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check("oe in hw standby", 32'h0, {24'h0, pin_oe});
        @(posedge pclk);
        hw_standby <= 1'b0;
        repeat (2) @(posedge pclk);
        rd_chk("direction cleared", port_a_pkg::LATCH_ADDR, 32'ha5, 1'b0);
        wr(port_a_pkg::DIR_ADDR, 8'hff);
        rd_chk("latch cleared", port_a_pkg::LATCH_ADDR, 32'h00, 1'b0);
        // Address mode: pin 7 stays an output carrying the address bit.
        do_reset(3'h3);
        ext_level   <= 8'hff;
        address_a20 <= 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check("oe mode 3", 32'h80, {24'h0, pin_oe});
        check("address high", 32'h1, {31'h0, pin_out[7]});
        wr(port_a_pkg::DIR_ADDR, 8'h00);
        rd_chk("pin 7 forced", port_a_pkg::LATCH_ADDR, 32'h7f, 1'b0);
        @(posedge pclk);
        address_a20 <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check("address low", 32'h0, {31'h0, pin_out[7]});
        check("oe pin 7 kept", 32'h80, {24'h0, pin_oe});
        finish_test();
    end
endmodule // port_a_io_port_test

`default_nettype wire
